/* File: design/dpm_pkg.sv */
// Shared constants and carrier types for the dual-port RAM with burst
// counters, counter masks and mailbox flags.
// Assumes a single 25 MHz clock and an AHB-Lite register bus.
package dpm_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANE_N = 4;
  localparam int LANE_W = 9;
  localparam int PORT_N = 2;
  localparam int PORT_L = 0;
  localparam int PORT_R = 1;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_CNT_L = 8'h08;
  localparam logic [7:0] OFS_CNT_R = 8'h0c;
  localparam logic [7:0] OFS_MASK_L = 8'h10;
  localparam logic [7:0] OFS_MASK_R = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_SOFT_CLR = 0;
  localparam int CTRL_DIS_L = 1;
  localparam int CTRL_DIS_R = 2;
  localparam int FLAGS_MBOX_L = 0;
  localparam int FLAGS_MBOX_R = 1;
  localparam int FLAGS_WRAP_L = 2;
  localparam int FLAGS_WRAP_R = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CNT_RST = 18'h00000;
  localparam logic [ADDR_W-1:0] MASK_RST = 18'h3ffff;
  localparam logic FLAG_RST = 1'b1;
  localparam logic [1:0] CTRL_DIS_RST = 2'h0;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Pins of one port, as seen at the device
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic addr_strobe_n;
    logic count_advance_n;
    logic counter_clear_n;
    logic mask_access_sel;
    logic chip_sel_low_n;
    logic chip_sel_high;
    logic rd_wr;
    logic [LANE_N-1:0] byte_lane_sel_n;
    logic out_en_n;
    logic [DATA_W-1:0] dq_in;
  } dpm_pin_in_t;

  // Counter state of one port
  typedef struct packed {
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] mask;
    logic wrap_n;
  } dpm_cnt_t;

  // One array access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [LANE_N-1:0] lanes;
    logic [DATA_W-1:0] data;
  } dpm_acc_t;

endpackage : dpm_pkg

/* File: design/dpm_top.sv */
// Dual-port RAM core: two pin ports with burst counters, counter masks,
// wrap flags and mailbox flags, plus an AHB-Lite status/control slave.
// Assumes both ports are driven from logic outside hclk's domain, so
// every port pin is synchronised before use.
//
// Function
// - Strobe low loads the presented address into the burst counter.
// - Advance low increments the counter once per clock edge.
// - Strobe or clear low suppresses the increment that cycle.
// - Clear low zeroes only the counter bits left unmasked.
// - Clear wins over strobe and advance in the same cycle.
// - Mask select low routes counter controls to the mask register.
// - Mask select high hides the mask; counter follows its controls.
// - Array access only with low-select low and high-select high; counters ignore both selects.
// - Data lines drive on reads only while output enable is low.
// - Opposite port writing a port's mailbox drives its flag low.
// - Owner reading its own mailbox returns its flag high.
// - Two highest addresses are the mailboxes, one per port.
// - Increment making unmasked counter bits all ones drives wrap low.
// - Global clear zeroes counters, masks to ones, flags high.
// - Read/write low writes the array, high reads it.
// - Byte lanes gate data; one lane needed for mailbox effects.
// - Top address is the right mailbox, next the left mailbox.
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module dpm_top #(
  parameter int DEPTH_W = dpm_pkg::ADDR_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic global_clear_n,
  input wire dpm_pkg::dpm_pin_in_t port_in [dpm_pkg::PORT_N],
  output logic [dpm_pkg::DATA_W-1:0] dq_out [dpm_pkg::PORT_N],
  output logic [dpm_pkg::DATA_W-1:0] dq_oe [dpm_pkg::PORT_N],
  output logic [dpm_pkg::PORT_N-1:0] mbox_flag_n,
  output logic [dpm_pkg::PORT_N-1:0] wrap_flag_n
);
  import dpm_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  localparam logic [DEPTH_W-1:0] TOP_IDX = '1;

  // Mailbox owned by a port: right owns the top word, left the one below
  function automatic logic is_mbox(input logic [ADDR_W-1:0] a,
                                   input int owner);
    logic [DEPTH_W-1:0] idx;
    idx = a[DEPTH_W-1:0];
    if (owner == PORT_R) begin
      is_mbox = (idx == TOP_IDX);
    end else begin
      is_mbox = (idx == TOP_IDX - 1'b1);
    end
  endfunction : is_mbox

  // Increment inside the unmasked bits only
  function automatic logic [ADDR_W-1:0] masked_inc(
      input logic [ADDR_W-1:0] c, input logic [ADDR_W-1:0] m);
    logic [ADDR_W-1:0] sum;
    sum = (c & m) + 1'b1;
    masked_inc = (sum & m) | (c & ~m);
  endfunction : masked_inc

  // Global clear is folded into the asynchronous reset of the port, counter and mailbox state
  logic arst_n;
  assign arst_n = hresetn & global_clear_n;

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  logic ph_valid_q, ph_valid_d;
  logic ph_write_q, ph_write_d;
  logic [7:0] ph_addr_q, ph_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic soft_clr_q, soft_clr_d;
  logic [1:0] dis_q, dis_d;
  dpm_cnt_t st_q [PORT_N];
  logic [PORT_N-1:0] mbox_q;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == OFS_CTRL) begin
      v[CTRL_DIS_L] = dis_q[0];
      v[CTRL_DIS_R] = dis_q[1];
    end else if (a == OFS_FLAGS) begin
      v[FLAGS_MBOX_L] = mbox_q[PORT_L];
      v[FLAGS_MBOX_R] = mbox_q[PORT_R];
      v[FLAGS_WRAP_L] = st_q[PORT_L].wrap_n;
      v[FLAGS_WRAP_R] = st_q[PORT_R].wrap_n;
    end else if (a == OFS_CNT_L) begin
      v[ADDR_W-1:0] = st_q[PORT_L].cnt;
    end else if (a == OFS_CNT_R) begin
      v[ADDR_W-1:0] = st_q[PORT_R].cnt;
    end else if (a == OFS_MASK_L) begin
      v[ADDR_W-1:0] = st_q[PORT_L].mask;
    end else if (a == OFS_MASK_R) begin
      v[ADDR_W-1:0] = st_q[PORT_R].mask;
    end
    reg_read = v;
  endfunction : reg_read

  // Zero wait states: read data is sampled at the address phase edge
  always_comb begin
    logic take;
    take = hsel && hready && (htrans == HTRANS_NONSEQ);
    ph_valid_d = take;
    ph_write_d = take && hwrite;
    ph_addr_d = take ? haddr[7:0] : ph_addr_q;
    hrdata_d = (take && !hwrite) ? reg_read(haddr[7:0]) : hrdata_q;
    soft_clr_d = 1'b0;
    dis_d = dis_q;
    if (ph_valid_q && ph_write_q && ph_addr_q == OFS_CTRL) begin
      soft_clr_d = hwdata[CTRL_SOFT_CLR];
      dis_d = {hwdata[CTRL_DIS_R], hwdata[CTRL_DIS_L]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q <= 8'h00;
      hrdata_q <= 32'h0;
      soft_clr_q <= 1'b0;
      dis_q <= CTRL_DIS_RST;
    end else begin
      ph_valid_q <= ph_valid_d;
      ph_write_q <= ph_write_d;
      ph_addr_q <= ph_addr_d;
      hrdata_q <= hrdata_d;
      soft_clr_q <= soft_clr_d;
      dis_q <= dis_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;

  // ----------------------------------------------------------------------
  // Port pipelines
  // ----------------------------------------------------------------------
  dpm_pin_in_t sync1_q [PORT_N];
  dpm_pin_in_t sync2_q [PORT_N];
  dpm_cnt_t st_d [PORT_N];
  dpm_acc_t acc [PORT_N];
  logic [DATA_W-1:0] rd_data_q [PORT_N];
  logic [LANE_N-1:0] rd_lane_q [PORT_N];
  logic [LANE_N-1:0] rd_lane_d [PORT_N];
  logic [DATA_W-1:0] mem_q [2**DEPTH_W];

  genvar p;
  generate
    for (p = 0; p < PORT_N; p++) begin : g_port
      // Pins come from another domain; two stages before any use
      always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_q[p] <= '1;
          sync2_q[p] <= '1;
        end else begin
          sync1_q[p] <= port_in[p];
          sync2_q[p] <= sync1_q[p];
        end
      end

      always_comb begin
        dpm_pin_in_t s;
        logic sel;
        logic cnt_mode;
        logic [ADDR_W-1:0] inc;
        s = sync2_q[p];
        st_d[p] = st_q[p];
        sel = !s.chip_sel_low_n && s.chip_sel_high && !dis_q[p];
        cnt_mode = s.mask_access_sel;
        inc = masked_inc(st_q[p].cnt, st_q[p].mask);
        // Access uses the pins' address when strobed, else the counter
        acc[p].addr = !s.addr_strobe_n ? s.addr : st_q[p].cnt;
        acc[p].lanes = ~s.byte_lane_sel_n;
        acc[p].data = s.dq_in;
        // Mask mode blocks array access so mask loads cannot corrupt data
        acc[p].wr = sel && cnt_mode && !s.rd_wr && (|acc[p].lanes);
        acc[p].rd = sel && cnt_mode && s.rd_wr && (|acc[p].lanes);
        rd_lane_d[p] = acc[p].rd ? acc[p].lanes : 4'h0;
        if (soft_clr_q) begin
          st_d[p].cnt = CNT_RST;
          st_d[p].mask = MASK_RST;
          st_d[p].wrap_n = FLAG_RST;
        end else if (!cnt_mode) begin
          if (!s.counter_clear_n) begin
            st_d[p].mask = MASK_RST;
          end else if (!s.addr_strobe_n) begin
            st_d[p].mask = s.addr;
          end
        end else if (!s.counter_clear_n) begin
          st_d[p].cnt = st_q[p].cnt & ~st_q[p].mask;
          st_d[p].wrap_n = 1'b1;
        end else if (!s.addr_strobe_n) begin
          st_d[p].cnt = s.addr;
          st_d[p].wrap_n = 1'b1;
        end else if (!s.count_advance_n) begin
          st_d[p].cnt = inc;
          st_d[p].wrap_n = ((inc & st_q[p].mask) != st_q[p].mask);
        end
      end

      always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
          st_q[p] <= {CNT_RST, MASK_RST, FLAG_RST};
          rd_lane_q[p] <= 4'h0;
        end else begin
          st_q[p] <= st_d[p];
          rd_lane_q[p] <= rd_lane_d[p];
        end
      end

      // Read data is registered; lanes not read are held at zero
      always_ff @(posedge hclk) begin
        for (int b = 0; b < LANE_N; b++) begin
          if (acc[p].rd && acc[p].lanes[b]) begin
            rd_data_q[p][b*LANE_W +: LANE_W] <=
              mem_q[acc[p].addr[DEPTH_W-1:0]][b*LANE_W +: LANE_W];
          end else begin
            rd_data_q[p][b*LANE_W +: LANE_W] <= '0;
          end
        end
      end

      assign dq_out[p] = rd_data_q[p];
      // Enable follows synchronised output enable, so it lags the pin
      for (genvar b = 0; b < LANE_N; b++) begin : g_lane
        assign dq_oe[p][b*LANE_W +: LANE_W] =
          {LANE_W{rd_lane_q[p][b] && !sync2_q[p].out_en_n}};
      end
      assign wrap_flag_n[p] = st_q[p].wrap_n;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Memory array
  // ----------------------------------------------------------------------
  // Same-word writes from both ports collide; the right port is applied
  // last so the outcome is at least deterministic.
  always_ff @(posedge hclk) begin
    for (int q = 0; q < PORT_N; q++) begin
      for (int b = 0; b < LANE_N; b++) begin
        if (acc[q].wr && acc[q].lanes[b]) begin
          mem_q[acc[q].addr[DEPTH_W-1:0]][b*LANE_W +: LANE_W] <=
            acc[q].data[b*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mailbox flags
  // ----------------------------------------------------------------------
  logic [PORT_N-1:0] mbox_d;

  always_comb begin
    for (int q = 0; q < PORT_N; q++) begin
      logic set;
      logic clr;
      set = acc[PORT_N-1-q].wr && is_mbox(acc[PORT_N-1-q].addr, q);
      clr = acc[q].rd && is_mbox(acc[q].addr, q);
      // A message landing in the soft-clear cycle must not be lost
      if (set) begin
        mbox_d[q] = 1'b0;
      end else if (soft_clr_q) begin
        mbox_d[q] = FLAG_RST;
      end else if (clr) begin
        mbox_d[q] = 1'b1;
      end else begin
        mbox_d[q] = mbox_q[q];
      end
    end
  end

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      mbox_q <= {PORT_N{FLAG_RST}};
    end else begin
      mbox_q <= mbox_d;
    end
  end

  assign mbox_flag_n = mbox_q;

endmodule : dpm_top

`default_nettype wire

/* File: testbench/dpm_top_sva.sv */
// Checker for dpm_top: bus answers, flag causes and lane enables.
// Assumes pins act three edges after the checker first samples them, output enable two.
`timescale 1ns/1ns
`default_nettype none
module dpm_top_sva #(
  parameter int DEPTH_W = 18
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic global_clear_n,
  input wire dpm_pkg::dpm_pin_in_t port_in [dpm_pkg::PORT_N],
  input wire logic [dpm_pkg::DATA_W-1:0] dq_oe [dpm_pkg::PORT_N],
  input wire logic [dpm_pkg::PORT_N-1:0] mbox_flag_n,
  input wire logic [dpm_pkg::PORT_N-1:0] wrap_flag_n
);
  import dpm_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn || !global_clear_n);
  logic rd_a;
  assign rd_a = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  property p_okay; hresp == HRESP_OKAY && hreadyout; endproperty
  a_okay: assert property (p_okay) else $error("bus answer wrong");
  property p_unmapped; rd_a && haddr[7:0] == 8'h20 |=> hrdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  property p_flags; rd_a && haddr[7:0] == OFS_FLAGS |=>
    hrdata == {28'h0, $past(wrap_flag_n), $past(mbox_flag_n)}; endproperty
  a_flags: assert property (p_flags) else $error("flag word wrong");
  property p_mbox_set; $fell(mbox_flag_n[1]) |->
    !$past(port_in[0].rd_wr, 3) && $past(port_in[0].chip_sel_high, 3);
  endproperty
  a_mbox_set: assert property (p_mbox_set)
    else $error("right flag set without left write");
  property p_mbox_clr; $rose(mbox_flag_n[1]) |->
    $past(port_in[1].rd_wr, 3); endproperty
  a_mbox_clr: assert property (p_mbox_clr)
    else $error("right flag cleared without read");
  property p_mbox_lanes; $fell(mbox_flag_n[0]) |->
    $past(port_in[1].byte_lane_sel_n, 3) != 4'hf; endproperty
  a_mbox_lanes: assert property (p_mbox_lanes)
    else $error("flag set with no lane");
  property p_wrap; $fell(wrap_flag_n[0]) |->
    !$past(port_in[0].count_advance_n, 3) &&
    $past(port_in[0].addr_strobe_n, 3) &&
    $past(port_in[0].counter_clear_n, 3); endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap without increment");
  property p_wrap_clr; !port_in[0].counter_clear_n &&
    port_in[0].mask_access_sel |-> ##3 wrap_flag_n[0]; endproperty
  a_wrap_clr: assert property (p_wrap_clr)
    else $error("wrap low after clear");
  property p_oe_en; dq_oe[1] != '0 |-> !$past(port_in[1].out_en_n, 2);
  endproperty
  a_oe_en: assert property (p_oe_en)
    else $error("drive without output enable");
  property p_oe_rd; dq_oe[1] != '0 |-> $past(port_in[1].rd_wr, 3) &&
    !$past(port_in[1].chip_sel_low_n, 3) &&
    $past(port_in[1].chip_sel_high, 3); endproperty
  a_oe_rd: assert property (p_oe_rd)
    else $error("drive without selected read");
  c_mbox: cover property ($fell(mbox_flag_n[1]));
  c_wrap: cover property ($fell(wrap_flag_n[0]));
  c_oe: cover property (dq_oe[1] != '0);
endmodule : dpm_top_sva
bind dpm_top dpm_top_sva #(.DEPTH_W(DEPTH_W)) u_sva (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .global_clear_n(global_clear_n),
  .port_in(port_in), .dq_oe(dq_oe), .mbox_flag_n(mbox_flag_n),
  .wrap_flag_n(wrap_flag_n));
`default_nettype wire

/* File: testbench/dpm_host.sv */
// Pin-side host of one port: drives one operation, then idles.
// Assumes the caller waits for op to return before the next one.
`timescale 1ns/1ns
`default_nettype none
module dpm_host (
  input wire logic clk,
  output var dpm_pkg::dpm_pin_in_t pins
);
  import dpm_pkg::*;
  initial pins = {18'h0, 4'hf, 8'hbf, 36'h0};
  // c: strobe_n advance_n clear_n mask_sel
  // s: sel_low_n sel_high rd_wr lanes out_en_n
  task automatic op(logic [17:0] a, logic [3:0] c, logic [7:0] s,
                    logic [35:0] d, int n);
    @(posedge clk);
    pins <= {a, c, s, d};
    repeat (n) @(posedge clk);
    // Released address and data lines inverted so stale values never pass
    pins <= {~a, 4'hf, 7'h5f, s[0], ~d};
    repeat (4) @(posedge clk);
  endtask : op
endmodule : dpm_host
`default_nettype wire

/* File: testbench/tb.sv */
// Testbench for dpm_top: two pin hosts, bus master, scoreboard.
// Assumes zero-wait bus answers and a small array depth.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dpm_pkg::*;
  localparam int DW = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic global_clear_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  dpm_pin_in_t pin [PORT_N];
  logic [DATA_W-1:0] dq_out [PORT_N], dq_oe [PORT_N];
  logic [PORT_N-1:0] mbox_flag_n, wrap_flag_n;
  int errors = 0, cmp_count = 0;
  logic [31:0] rq [$];
  logic [DATA_W-1:0] dq [$];
  logic [DATA_W-1:0] lq [$];
  logic dp_rd = 1'b0;
  logic [DATA_W-1:0] d;
  logic [17:0] a;
  assign hready = hreadyout;
  dpm_top #(.DEPTH_W(DW)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .global_clear_n(global_clear_n), .port_in(pin), .dq_out(dq_out),
    .dq_oe(dq_oe), .mbox_flag_n(mbox_flag_n), .wrap_flag_n(wrap_flag_n));
  dpm_host hl (.clk(hclk), .pins(pin[0]));
  dpm_host hr (.clk(hclk), .pins(pin[1]));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // --------------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------------
  task automatic chk_reg(logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected hrdata exp %h got %h", e, g);
    end
  endtask : chk_reg
  task automatic chk_dq(logic [35:0] e, logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected dq_out exp %h got %h", e, g);
    end
  endtask : chk_dq
  always @(posedge hclk) begin
    if (dp_rd && hreadyout) chk_reg(rq.pop_front(), hrdata);
    if (dq_oe[1] !== '0) chk_dq(dq.pop_front(), dq_out[1]);
    if (dq_oe[0] !== '0) chk_dq(lq.pop_front(), dq_out[0]);
    dp_rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  end
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic done(string s);
    $display("test %s finished", s);
  endtask : done
  // --------------------------------------------------------------------
  // Bus master: read expectation goes with the request
  // --------------------------------------------------------------------
  task automatic bus(logic [7:0] ad, logic w, logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= v;
    if (!w) rq.push_back(v);
    do @(posedge hclk); while (!hreadyout);
  endtask : bus
  initial begin
    repeat (4000) @(posedge hclk);
    errors++;
    wrap_up();
  end
  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    global_clear_n = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    void'($urandom(32'hebaa));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(OFS_FLAGS, 0, 32'hf);
    bus(OFS_CNT_L, 0, 32'h0);
    bus(OFS_MASK_R, 0, 32'h3ffff);
    bus(8'h20, 0, 32'h0);
    done("reset");
    a = 18'($urandom_range(7));
    hl.op(a, 4'h7, 8'hbf, '0, 1);
    bus(OFS_CNT_L, 0, {14'h0, a});
    hl.op(~a, 4'hb, 8'hbf, '0, 3);
    bus(OFS_CNT_L, 0, {14'h0, a + 18'h3});
    hl.op(18'h9, 4'h3, 8'hbf, '0, 1);
    bus(OFS_CNT_L, 0, 32'h9);
    hl.op(18'h5, 4'h1, 8'hbf, '0, 1);
    bus(OFS_CNT_L, 0, 32'h0);
    hl.op(18'h3, 4'h6, 8'hbf, '0, 1);
    bus(OFS_MASK_L, 0, 32'h3);
    bus(OFS_CNT_L, 0, 32'h0);
    hl.op(18'h6, 4'h7, 8'hbf, '0, 1);
    hl.op(18'h0, 4'hb, 8'hbf, '0, 1);
    bus(OFS_FLAGS, 0, 32'hb);
    hl.op(18'h0, 4'hb, 8'hbf, '0, 1);
    bus(OFS_CNT_L, 0, 32'h4);
    hl.op(18'h0, 4'hd, 8'hbf, '0, 1);
    bus(OFS_CNT_L, 0, 32'h4);
    bus(OFS_FLAGS, 0, 32'hf);
    hl.op(18'h0, 4'hc, 8'hbf, '0, 1);
    bus(OFS_MASK_L, 0, 32'h3ffff);
    bus(OFS_CTRL, 1, 32'h1);
    bus(OFS_CNT_L, 0, 32'h0);
    done("counter");
    d = DATA_W'({$urandom, $urandom});
    hl.op(18'hf, 4'h7, 8'h5f, d, 1);
    hl.op(18'hf, 4'h7, 8'h01, d, 1);
    bus(OFS_CTRL, 1, 32'h2);
    hl.op(18'hf, 4'h7, 8'h41, d, 1);
    bus(OFS_FLAGS, 0, 32'hf);
    bus(OFS_CTRL, 1, 32'h0);
    hl.op(18'hf, 4'h7, 8'h41, d, 1);
    bus(OFS_FLAGS, 0, 32'hd);
    hr.op(18'he, 4'h7, 8'h41, ~d, 1);
    bus(OFS_FLAGS, 0, 32'hc);
    hr.op(18'hf, 4'h7, 8'h61, '0, 1);
    bus(OFS_FLAGS, 0, 32'he);
    dq.push_back(~d);
    hr.op(18'he, 4'h7, 8'h60, '0, 1);
    dq.push_back(d);
    hr.op(18'hf, 4'h7, 8'h60, '0, 1);
    lq.push_back(~d);
    hl.op(18'he, 4'h7, 8'h60, '0, 1);
    bus(OFS_FLAGS, 0, 32'hf);
    done("mailbox");
    hl.op(18'h5, 4'h7, 8'hbf, '0, 1);
    hr.op(18'he, 4'h7, 8'h41, d, 1);
    @(posedge hclk);
    global_clear_n <= 1'b0;
    @(posedge hclk);
    global_clear_n <= 1'b1;
    bus(OFS_CNT_L, 0, 32'h0);
    bus(OFS_FLAGS, 0, 32'hf);
    chk_dq('0, DATA_W'(dq.size()));
    chk_dq('0, DATA_W'(lq.size()));
    done("clear");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
